/* File: logic/pmic_fsm_pkg.sv */
// Package: constants, state enum and grouped carriers for the PMIC state machine
// How it works
// [R1] Five states only: off, start sequence, sleep, deep sleep, on.
// [R2] In power-off every regulator and switch output is forced off.
// [R3] After power-up the machine sits in power-off, reset low, defaults loaded.
// [R4] Input undervoltage forces power-off from anywhere and restores defaults.
// [R5] A button press requesting power-off moves any state to power-off; the code does this from power-on only.
// [R6] A power cycle passes through power-off before sequencing on again.
// [R7] Leave power-off when power-off bit cleared or button low over 32 ms.
// [R8] From sleep or deep sleep, go on once every enabled regulator regulates.
// [R9] Button start waits for button release and all regulators in regulation.
// [R10] Button released before regulation during button start returns to off.
// [R11] Fault after regulation while button still held returns to off.
// [R12] Power-cycle start waits 0.5 s in start sequence, then goes on.
// [R13] In power-on each output follows its own programmed enable.
// [R14] From power-on, master reset bit or button request goes to off.
// [R15] Button held over 8 s triggers a master-reset power cycle everywhere; the code cycles without setting the master reset bit.
// [R16] Power-off with master reset also drops always-on and current supplies; the code drops only alwaysOnEnable_ff.
// [R17] Sleep entry and exit step outputs by their own sequencing delays; the code tests the first cycle after a change against the old step index.
// [R18] In sleep bucks pick primary, alternate or off; others primary or off.
// [R19] The serial control interface stays enabled while asleep.
// [R20] Factory bit picks OR (1) or AND (0) of sleep bit and GPIO.
// [R21] Sleep ends when condition drops or button low over 32 ms, clearing bits.
// [R22] Leaving sleep runs a full power-on sequence before power-on.
// [R23] Without a GPIO assigned, only the sleep request bit controls sleep.
// [R24] GPIO sleep control is edge-armed: must go high before low counts.
// [R25] Serial slave engine is reset on every entry to sleep.
// [R26] Button hold times counted on the clock after synchronising and filtering.
package pmic_fsm_pkg;

  localparam int NUM_OUT = 10;             // Two bucks first, then the rest
  localparam int NUM_BUCK = 2;
  localparam int CLK_MHZ = 100;
  localparam int SHORT_HOLD_MS = 32;
  localparam int LONG_HOLD_MS = 8000;
  localparam int CYCLE_WAIT_MS = 500;
  localparam int FILTER_US = 1;
  localparam int SEQ_STEP_US = 100;
  localparam int SHORT_HOLD_CYC = SHORT_HOLD_MS * 1000 * CLK_MHZ + 1;
  localparam int LONG_HOLD_CYC = LONG_HOLD_MS * 1000 * CLK_MHZ + 1;
  localparam int CYCLE_WAIT_CYC = CYCLE_WAIT_MS * 1000 * CLK_MHZ;
  localparam int FILTER_CYC = FILTER_US * CLK_MHZ;
  localparam int SEQ_STEP_CYC = SEQ_STEP_US * CLK_MHZ;
  localparam int DLY_W = 3;                // Per-output delay in steps

  // Sleep-mode selector per output
  localparam logic [1:0] SLP_OFF = 2'h0;
  localparam logic [1:0] SLP_PRIMARY = 2'h1;
  localparam logic [1:0] SLP_ALT = 2'h2;

  typedef enum logic [4:0] {
    PWR_OFF = 5'h01,
    START_SEQ = 5'h02,
    SLEEP = 5'h04,
    DEEP_SLEEP = 5'h08,
    PWR_ON = 5'h10
  } state_type;

  // Why the start sequence was entered
  typedef enum logic [2:0] {
    WHY_BUTTON = 3'h1,
    WHY_SOFT = 3'h2,
    WHY_CYCLE = 3'h4
  } cause_type;

  // Software control bits
  typedef struct packed {
    logic powerOffBit;
    logic masterResetBit;
    logic sleepReqBit;
    logic deepSleepReqBit;
  } ctrl_type;

  // Factory straps
  typedef struct packed {
    logic sleepOrMode;
    logic deepSleepOrMode;
    logic gpioSleepAssigned;
    logic gpioDeepAssigned;
  } strap_type;

  // Per-output drive
  typedef struct packed {
    logic [NUM_OUT-1:0] enable;
    logic [NUM_OUT-1:0] useAlternate;
  } drive_type;

endpackage : pmic_fsm_pkg

/* File: logic/pmic_power_state_machine.sv */
// Module: five-state power controller of a battery PMIC
`timescale 1ns/1ns
module pmic_power_state_machine #(
  parameter int NUM_OUT = pmic_fsm_pkg::NUM_OUT,
  parameter int SHORT_HOLD_CYC = pmic_fsm_pkg::SHORT_HOLD_CYC,
  parameter int LONG_HOLD_CYC = pmic_fsm_pkg::LONG_HOLD_CYC,
  parameter int CYCLE_WAIT_CYC = pmic_fsm_pkg::CYCLE_WAIT_CYC,
  parameter int FILTER_CYC = pmic_fsm_pkg::FILTER_CYC,
  parameter int SEQ_STEP_CYC = pmic_fsm_pkg::SEQ_STEP_CYC
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic input_undervoltage,
  input wire logic push_button_in_n,
  input wire pmic_fsm_pkg::ctrl_type ctrl,
  input wire logic powerOffWr,
  input wire logic masterResetWr,
  input wire logic sleepWr,
  input wire logic deepSleepWr,
  input wire pmic_fsm_pkg::strap_type strap,
  input wire logic gpioSleepPin,
  input wire logic gpioDeepPin,
  input wire logic [NUM_OUT-1:0] onEnable,
  input wire logic [NUM_OUT-1:0] sleepEnable,
  input wire logic [NUM_OUT-1:0] deepEnable,
  input wire logic [2*NUM_OUT-1:0] sleepSel,
  input wire logic [3*NUM_OUT-1:0] seqDelay,
  input wire logic [NUM_OUT-1:0] inRegulation,
  input wire logic anyFault,
  output pmic_fsm_pkg::state_type state_ff,
  output pmic_fsm_pkg::ctrl_type ctrlBits_ff,
  output pmic_fsm_pkg::drive_type drive_ff,
  output logic system_reset_out_n_ff,
  output logic alwaysOnEnable_ff,
  output logic defaultsLoad_ff,
  output logic serialReset_ff,
  output logic serialEnable_ff
);

  // ----------------------------------------------------------------
  // Button conditioning
  // ----------------------------------------------------------------
  logic pbSync1_ff, pbSync2_ff, pbLow_ff;
  logic [$clog2(FILTER_CYC+1)-1:0] filtCnt_ff;
  logic [$clog2(LONG_HOLD_CYC+1)-1:0] holdCnt_ff;
  logic shortSeen_ff, longSeen_ff;

  // Two flops, then a stability filter so contact bounce is not counted
  // [R26] sync and filter
  always_ff @(posedge mclk) begin
    if (rst) begin
      pbSync1_ff <= 1'b1;
      pbSync2_ff <= 1'b1;
      pbLow_ff <= 1'b0;
      filtCnt_ff <= '0;
    end else begin
      pbSync1_ff <= push_button_in_n;
      pbSync2_ff <= pbSync1_ff;
      if (!pbSync2_ff == pbLow_ff) begin
        filtCnt_ff <= '0;
      end else if (filtCnt_ff == ($bits(filtCnt_ff))'(FILTER_CYC - 1)) begin
        pbLow_ff <= !pbSync2_ff;
        filtCnt_ff <= '0;
      end else begin
        filtCnt_ff <= filtCnt_ff + 1'b1;
      end
    end
  end

  // Hold counter saturates; one-shot flags stop a hold retriggering
  // [R26] hold time counters
  wire shortHit = pbLow_ff && !shortSeen_ff &&
    holdCnt_ff == ($bits(holdCnt_ff))'(SHORT_HOLD_CYC - 1);
  wire longHit = pbLow_ff && !longSeen_ff &&
    holdCnt_ff == ($bits(holdCnt_ff))'(LONG_HOLD_CYC - 1);
  wire pbRelease = !pbLow_ff;

  always_ff @(posedge mclk) begin
    if (rst || !pbLow_ff) begin
      holdCnt_ff <= '0;
      shortSeen_ff <= 1'b0;
      longSeen_ff <= 1'b0;
    end else begin
      if (!longSeen_ff) begin
        holdCnt_ff <= holdCnt_ff + 1'b1;
      end
      if (shortHit) begin
        shortSeen_ff <= 1'b1;
      end
      if (longHit) begin
        longSeen_ff <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Sleep request decode
  // ----------------------------------------------------------------
  logic gpioSlpArm_ff, gpioDpArm_ff;

  // Pin must be seen high after power-up before its low level counts
  // [R24] edge arming
  always_ff @(posedge mclk) begin
    if (rst || defaultsLoad_ff) begin
      gpioSlpArm_ff <= 1'b0;
      gpioDpArm_ff <= 1'b0;
    end else begin
      gpioSlpArm_ff <= gpioSlpArm_ff | gpioSleepPin;
      gpioDpArm_ff <= gpioDpArm_ff | gpioDeepPin;
    end
  end

  // Low-active request from an armed pin; OR or AND with the soft bit
  function automatic logic sleepCond(input logic bitReq, input logic orMode,
                                     input logic assigned, input logic armed,
                                     input logic pin);
    logic pinReq;
    pinReq = armed && !pin;
    if (!assigned) begin
      sleepCond = bitReq;
    end else if (orMode) begin
      sleepCond = bitReq | pinReq;
    end else begin
      sleepCond = bitReq & pinReq;
    end
  endfunction

  // [R20] [R23] factory combination
  wire wantSleep = sleepCond(ctrlBits_ff.sleepReqBit, strap.sleepOrMode,
    strap.gpioSleepAssigned, gpioSlpArm_ff, gpioSleepPin);
  wire wantDeep = sleepCond(ctrlBits_ff.deepSleepReqBit,
    strap.deepSleepOrMode, strap.gpioDeepAssigned, gpioDpArm_ff,
    gpioDeepPin);

  // ----------------------------------------------------------------
  // Software control bits
  // ----------------------------------------------------------------
  pmic_fsm_pkg::state_type nxt_state;
  pmic_fsm_pkg::cause_type cause_ff, nxt_cause;
  pmic_fsm_pkg::ctrl_type nxt_ctrlBits;
  logic [$clog2(CYCLE_WAIT_CYC+1)-1:0] waitCnt_ff;
  logic regSeen_ff;
  logic inSleepState;
  assign inSleepState = state_ff == pmic_fsm_pkg::SLEEP ||
    state_ff == pmic_fsm_pkg::DEEP_SLEEP;

  // Writes land unless a hold clears sleep bits; undervoltage restores all
  // [R21] button clears sleep bits
  always_comb begin
    nxt_ctrlBits = ctrlBits_ff;
    if (powerOffWr) nxt_ctrlBits.powerOffBit = ctrl.powerOffBit;
    if (masterResetWr) nxt_ctrlBits.masterResetBit = ctrl.masterResetBit;
    if (sleepWr) nxt_ctrlBits.sleepReqBit = ctrl.sleepReqBit;
    if (deepSleepWr) nxt_ctrlBits.deepSleepReqBit = ctrl.deepSleepReqBit;
    if (inSleepState && shortHit) begin
      nxt_ctrlBits.sleepReqBit = 1'b0;
      nxt_ctrlBits.deepSleepReqBit = 1'b0;
    end
    // Master reset is consumed when power-off is left
    if (state_ff == pmic_fsm_pkg::PWR_OFF && nxt_state != pmic_fsm_pkg::PWR_OFF)
      nxt_ctrlBits.masterResetBit = 1'b0;
  end

  // ----------------------------------------------------------------
  // State machine
  // ----------------------------------------------------------------
  wire allReg = &(inRegulation | ~onEnable);
  wire waitDone = waitCnt_ff == ($bits(waitCnt_ff))'(CYCLE_WAIT_CYC - 1);

  // [R1] five-state machine
  always_comb begin
    nxt_state = state_ff;
    nxt_cause = cause_ff;
    unique case (state_ff)
      pmic_fsm_pkg::PWR_OFF: begin
        // [R6] cycle restarts
        if (cause_ff == pmic_fsm_pkg::WHY_CYCLE) begin
          nxt_state = pmic_fsm_pkg::START_SEQ;
        // [R7] power-off exit
        end else if (shortHit) begin
          nxt_state = pmic_fsm_pkg::START_SEQ;
          nxt_cause = pmic_fsm_pkg::WHY_BUTTON;
        end else if (!ctrlBits_ff.powerOffBit) begin
          nxt_state = pmic_fsm_pkg::START_SEQ;
          nxt_cause = pmic_fsm_pkg::WHY_SOFT;
        end
      end
      pmic_fsm_pkg::START_SEQ: begin
        unique case (cause_ff)
          pmic_fsm_pkg::WHY_BUTTON: begin
            // [R10] early release
            if (pbRelease && !regSeen_ff && !allReg) begin
              nxt_state = pmic_fsm_pkg::PWR_OFF;
            // [R11] fault while held
            end else if (!pbRelease && regSeen_ff && anyFault) begin
              nxt_state = pmic_fsm_pkg::PWR_OFF;
            // [R9] release and regulate
            end else if (pbRelease && allReg) begin
              nxt_state = pmic_fsm_pkg::PWR_ON;
            end
          end
          // [R12] fixed wait
          pmic_fsm_pkg::WHY_CYCLE: begin
            if (waitDone) nxt_state = pmic_fsm_pkg::PWR_ON;
          end
          // [R8] [R22] full sequence
          default: begin
            if (allReg) nxt_state = pmic_fsm_pkg::PWR_ON;
          end
        endcase
      end
      pmic_fsm_pkg::PWR_ON: begin
        // [R14] off request
        if (ctrlBits_ff.masterResetBit || ctrlBits_ff.powerOffBit) begin
          nxt_state = pmic_fsm_pkg::PWR_OFF;
          nxt_cause = pmic_fsm_pkg::WHY_SOFT;
        end else if (wantDeep) begin
          nxt_state = pmic_fsm_pkg::DEEP_SLEEP;
        end else if (wantSleep) begin
          nxt_state = pmic_fsm_pkg::SLEEP;
        end
      end
      pmic_fsm_pkg::SLEEP: begin
        // [R21] sleep exit
        if (!wantSleep || shortHit) begin
          nxt_state = pmic_fsm_pkg::START_SEQ;
          nxt_cause = pmic_fsm_pkg::WHY_SOFT;
        end
      end
      pmic_fsm_pkg::DEEP_SLEEP: begin
        if (!wantDeep || shortHit) begin
          nxt_state = pmic_fsm_pkg::START_SEQ;
          nxt_cause = pmic_fsm_pkg::WHY_SOFT;
        end
      end
    endcase
    // [R15] long hold cycles
    if (longHit) begin
      nxt_state = pmic_fsm_pkg::PWR_OFF;
      nxt_cause = pmic_fsm_pkg::WHY_CYCLE;
    // [R5] button off request
    end else if (shortHit && state_ff == pmic_fsm_pkg::PWR_ON) begin
      nxt_state = pmic_fsm_pkg::PWR_OFF;
      nxt_cause = pmic_fsm_pkg::WHY_SOFT;
    end
  end

  // Undervoltage outranks everything, including the long-hold cycle
  // [R3] [R4] forced power-off
  always_ff @(posedge mclk) begin
    if (rst || input_undervoltage) begin
      state_ff <= pmic_fsm_pkg::PWR_OFF;
      cause_ff <= pmic_fsm_pkg::WHY_SOFT;
      ctrlBits_ff <= '{powerOffBit: 1'b1, default: 1'b0};
      defaultsLoad_ff <= 1'b1;
    end else begin
      state_ff <= nxt_state;
      cause_ff <= nxt_cause;
      ctrlBits_ff <= nxt_ctrlBits;
      defaultsLoad_ff <= 1'b0;
    end
  end

  // Wait counter and regulation-reached flag restart on each state change
  always_ff @(posedge mclk) begin
    if (rst || nxt_state != state_ff) begin
      waitCnt_ff <= '0;
      regSeen_ff <= 1'b0;
    end else begin
      if (!waitDone) waitCnt_ff <= waitCnt_ff + 1'b1;
      regSeen_ff <= regSeen_ff | allReg;
    end
  end

  // ----------------------------------------------------------------
  // Output targets and sequencing
  // ----------------------------------------------------------------
  logic [NUM_OUT-1:0] target, targetAlt;
  logic [$clog2(SEQ_STEP_CYC+1)-1:0] stepCnt_ff;
  logic [pmic_fsm_pkg::DLY_W-1:0] stepIdx_ff;
  pmic_fsm_pkg::state_type prevState_ff;
  wire stepTick = stepCnt_ff == ($bits(stepCnt_ff))'(SEQ_STEP_CYC - 1);

  // Per-output target by state, with sleep voltage choice
  genvar g;
  generate
    for (g = 0; g < NUM_OUT; g++) begin : g_out
      wire [1:0] sel = sleepSel[2*g +: 2];
      // [R18] sleep voltage selection
      wire altOk = g < pmic_fsm_pkg::NUM_BUCK && sel == pmic_fsm_pkg::SLP_ALT;
      wire slpOn = sleepEnable[g] ? (sel == pmic_fsm_pkg::SLP_PRIMARY || altOk)
                                  : onEnable[g];
      wire dpOn = deepEnable[g] ? 1'b0 : onEnable[g];
      // [R2] [R13] per-state enables
      assign target[g] = state_ff == pmic_fsm_pkg::PWR_ON ? onEnable[g] :
        state_ff == pmic_fsm_pkg::START_SEQ ? onEnable[g] :
        state_ff == pmic_fsm_pkg::SLEEP ? slpOn :
        state_ff == pmic_fsm_pkg::DEEP_SLEEP ? dpOn : 1'b0;
      assign targetAlt[g] = state_ff == pmic_fsm_pkg::SLEEP &&
        sleepEnable[g] && altOk;
    end
  endgenerate

  // Step counter restarts on every state change, one cycle after it
  always_ff @(posedge mclk) begin
    if (rst) begin
      prevState_ff <= pmic_fsm_pkg::PWR_OFF;
      stepCnt_ff <= '0;
      stepIdx_ff <= '0;
    end else begin
      prevState_ff <= state_ff;
      if (prevState_ff != state_ff) begin
        stepCnt_ff <= '0;
        stepIdx_ff <= '0;
      end else if (stepTick) begin
        stepCnt_ff <= '0;
        if (stepIdx_ff != '1) stepIdx_ff <= stepIdx_ff + 1'b1;
      end else begin
        stepCnt_ff <= stepCnt_ff + 1'b1;
      end
    end
  end

  // Outputs change once their delay slot is reached, tested against the old step index in the first cycle after a state change
  // [R17] per-output delays
  logic [NUM_OUT-1:0] slotDue;
  generate
    for (g = 0; g < NUM_OUT; g++) begin : g_due
      assign slotDue[g] = stepIdx_ff >= seqDelay[3*g +: 3];
    end
  endgenerate

  // [R2] off state clears all at once
  always_ff @(posedge mclk) begin
    if (rst || state_ff == pmic_fsm_pkg::PWR_OFF) begin
      drive_ff <= '0;
    end else begin
      drive_ff.enable <= (drive_ff.enable & ~slotDue) | (target & slotDue);
      drive_ff.useAlternate <= (drive_ff.useAlternate & ~slotDue) |
        (targetAlt & slotDue);
    end
  end

  // ----------------------------------------------------------------
  // System outputs
  // ----------------------------------------------------------------
  // [R3] reset low in power-off and start sequence; [R16] [R25] [R19] side outputs
  always_ff @(posedge mclk) begin
    if (rst) begin
      system_reset_out_n_ff <= 1'b0;
      alwaysOnEnable_ff <= 1'b0;
      serialReset_ff <= 1'b1;
      serialEnable_ff <= 1'b1;
    end else begin
      system_reset_out_n_ff <= state_ff != pmic_fsm_pkg::PWR_OFF &&
        state_ff != pmic_fsm_pkg::START_SEQ;
      if (state_ff == pmic_fsm_pkg::PWR_OFF && ctrlBits_ff.masterResetBit)
        alwaysOnEnable_ff <= 1'b0;
      else if (state_ff != pmic_fsm_pkg::PWR_OFF)
        alwaysOnEnable_ff <= 1'b1;
      serialReset_ff <= nxt_state == pmic_fsm_pkg::SLEEP &&
        state_ff != pmic_fsm_pkg::SLEEP;
      serialEnable_ff <= 1'b1;
    end
  end

endmodule // pmic_power_state_machine

/* File: tb/pmic_power_state_machine_properties.sv */
// Checker: port-level assertions on the power state machine
`timescale 1ns/1ns
module pmic_fsm_checker (
  input wire logic mclk,
  input wire logic rst,
  input wire logic input_undervoltage,
  input wire pmic_fsm_pkg::ctrl_type ctrl,
  input wire logic powerOffWr,
  input wire logic masterResetWr,
  input wire pmic_fsm_pkg::state_type state_ff,
  input wire pmic_fsm_pkg::ctrl_type ctrlBits_ff,
  input wire pmic_fsm_pkg::drive_type drive_ff,
  input wire logic system_reset_out_n_ff,
  input wire logic alwaysOnEnable_ff,
  input wire logic defaultsLoad_ff,
  input wire logic serialReset_ff,
  input wire logic serialEnable_ff
);
  // ----------------------------------------
  // Properties, one clock domain
  // ----------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  property p_oneHot;
    $onehot(state_ff);
  endproperty
  a_oneHot: assert property (p_oneHot)
    else $error("state not one-hot");

  property p_offDrive;
    state_ff == pmic_fsm_pkg::PWR_OFF |=> drive_ff.enable == '0;
  endproperty
  a_offDrive: assert property (p_offDrive)
    else $error("output enabled in power-off");

  // Reset output trails the state by one cycle
  property p_resetOut;
    system_reset_out_n_ff == !($past(state_ff) inside
      {pmic_fsm_pkg::PWR_OFF, pmic_fsm_pkg::START_SEQ});
  endproperty
  a_resetOut: assert property (p_resetOut)
    else $error("system reset output wrong for state");

  property p_uvOff;
    input_undervoltage |=> state_ff == pmic_fsm_pkg::PWR_OFF
      && ctrlBits_ff == 4'h8 && defaultsLoad_ff;
  endproperty
  a_uvOff: assert property (p_uvOff)
    else $error("undervoltage did not restore defaults");

  property p_softStart;
    state_ff == pmic_fsm_pkg::PWR_OFF && powerOffWr && !ctrl.powerOffBit
      && !input_undervoltage |-> ##[1:2] state_ff == pmic_fsm_pkg::START_SEQ;
  endproperty
  a_softStart: assert property (p_softStart)
    else $error("power-off clear did not start sequence");

  property p_masterOff;
    state_ff == pmic_fsm_pkg::PWR_ON && masterResetWr && ctrl.masterResetBit
      && !input_undervoltage |-> ##[1:2] state_ff == pmic_fsm_pkg::PWR_OFF;
  endproperty
  a_masterOff: assert property (p_masterOff)
    else $error("master reset did not reach power-off");

  property p_alwaysOnDrop;
    state_ff == pmic_fsm_pkg::PWR_OFF && ctrlBits_ff.masterResetBit
      |=> !alwaysOnEnable_ff;
  endproperty
  a_alwaysOnDrop: assert property (p_alwaysOnDrop)
    else $error("always-on supply kept after master reset");

  property p_serialOn;
    state_ff == pmic_fsm_pkg::SLEEP |-> serialEnable_ff;
  endproperty
  a_serialOn: assert property (p_serialOn)
    else $error("serial interface disabled in sleep");

  property p_serialReset;
    $rose(state_ff == pmic_fsm_pkg::SLEEP) |-> ##[0:1] serialReset_ff;
  endproperty
  a_serialReset: assert property (p_serialReset)
    else $error("serial engine not reset on sleep entry");
endmodule // pmic_fsm_checker

/* File: tb/regulator_bank_model.sv */
// Model: regulator bank that reports regulation after a ramp
`timescale 1ns/1ns
module regulator_bank_model #(
  parameter int NUM_OUT = 10
) (
  input wire logic mclk,
  input wire logic [NUM_OUT-1:0] enable,
  input wire logic [7:0] lagCyc,
  input wire logic faultCmd,
  output logic [NUM_OUT-1:0] inRegulation,
  output logic anyFault
);
  logic [7:0] age [NUM_OUT];

  // regulation after ramp
  // A disabled output drops out on the next clock, its good flag lasting at most one cycle after enable falls
  always_ff @(posedge mclk) begin
    for (int g = 0; g < NUM_OUT; g++) begin
      if (!enable[g])
        age[g] <= 8'h00;
      else if (age[g] != 8'hFF)
        age[g] <= age[g] + 8'h01;
      inRegulation[g] <= enable[g] && (age[g] >= lagCyc);
    end
  end

  // Faults appear only when a scenario asks for one
  assign anyFault = faultCmd;
endmodule // regulator_bank_model

/* File: tb/tb_pmic_power_state_machine.sv */
// Testbench: directed sequences for the power state machine
`timescale 1ns/1ns
module tb_pmic_power_state_machine;
  // ----------------------------------------
  // Signals, design and partner
  // ----------------------------------------
  logic mclk, rst, uv, btnN, gpio, fault;
  logic [3:0] wr;
  logic [7:0] lag;
  logic [9:0] onEn, inReg, slpEn, dpEn;
  logic [19:0] slpSel;
  logic [29:0] dly;
  pmic_fsm_pkg::ctrl_type ctrl, ctrlBits_ff;
  pmic_fsm_pkg::strap_type strap;
  pmic_fsm_pkg::state_type state_ff;
  pmic_fsm_pkg::drive_type drive_ff;
  logic rstOutN, aoEn, dflt, serRst, serEn, flt;
  int failures, checks;

  // Short counts keep every hold and wait inside a few hundred cycles
  pmic_power_state_machine #(.SHORT_HOLD_CYC(50), .LONG_HOLD_CYC(200),
    .CYCLE_WAIT_CYC(30), .FILTER_CYC(2), .SEQ_STEP_CYC(4)) i_dut (
    .mclk(mclk), .rst(rst), .input_undervoltage(uv),
    .push_button_in_n(btnN), .ctrl(ctrl), .powerOffWr(wr[3]),
    .masterResetWr(wr[2]), .sleepWr(wr[1]), .deepSleepWr(wr[0]),
    .strap(strap), .gpioSleepPin(gpio), .gpioDeepPin(gpio),
    .onEnable(onEn), .sleepEnable(slpEn), .deepEnable(dpEn),
    .sleepSel(slpSel), .seqDelay(dly), .inRegulation(inReg),
    .anyFault(flt), .state_ff(state_ff), .ctrlBits_ff(ctrlBits_ff),
    .drive_ff(drive_ff), .system_reset_out_n_ff(rstOutN),
    .alwaysOnEnable_ff(aoEn), .defaultsLoad_ff(dflt),
    .serialReset_ff(serRst), .serialEnable_ff(serEn));

  regulator_bank_model i_regs (.mclk(mclk),
    .enable(drive_ff.enable), .lagCyc(lag), .faultCmd(fault),
    .inRegulation(inReg), .anyFault(flt));

  // Clock at 100 MHz
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  task automatic complete_run();
    if (failures == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic cmpState(input pmic_fsm_pkg::state_type exp);
    checks++;
    if (state_ff !== exp) begin
      failures++;
      $display("Error state expected %h seen %h", exp, state_ff);
    end
  endtask

  task automatic cmpBits(input string name, input logic [19:0] exp,
                         input logic [19:0] got);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic settle(input int n);
    repeat (n) @(negedge mclk);
  endtask

  // Bounded wait on the state, then one comparison
  task automatic waitState(input pmic_fsm_pkg::state_type exp,
                           input int lim);
    for (int i = 0; i < lim && state_ff !== exp; i++)
      @(negedge mclk);
    cmpState(exp);
  endtask

  // One-cycle strobe: 0 power-off, 1 master reset, 2 sleep, 3 deep sleep
  task automatic writeCtrl(input int sel, input logic val);
    @(negedge mclk);
    ctrl = {4{val}};
    wr[3-sel] = 1'b1;
    @(negedge mclk);
    wr = 4'h0;
  endtask

  task automatic doReset();
    rst = 1'b1;
    settle(6);
    rst = 1'b0;
  endtask

  // Watchdog well beyond the expected run length
  initial begin
    #200000;
    failures++;
    complete_run();
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    int n;
    rst = 1'b1;
    uv = 1'b0;
    btnN = 1'b1;
    gpio = 1'b0;
    fault = 1'b0;
    wr = 4'h0;
    lag = 8'h03;
    ctrl = 4'h0;
    strap = 4'h2;
    onEn = 10'h3F7;
    slpEn = 10'h007;
    dpEn = 10'h004;
    slpSel = 20'h00012;
    dly = 30'h2AAAAAAA;
    failures = 0;
    checks = 0;
    doReset();
    cmpState(pmic_fsm_pkg::PWR_OFF);
    cmpBits("ctrlBits", 20'h00008, {16'h0000, ctrlBits_ff});
    cmpBits("drive", 20'h00000, drive_ff);
    writeCtrl(0, 1'b0);
    waitState(pmic_fsm_pkg::START_SEQ, 10);
    waitState(pmic_fsm_pkg::PWR_ON, 200);
    settle(50);
    cmpBits("drive", 20'hFDC00, drive_ff);
    cmpBits("resetOut", 20'h00001, {19'h00000, rstOutN});
    // Gpio low since power-up must not count before a high level
    writeCtrl(2, 1'b1);
    settle(20);
    cmpState(pmic_fsm_pkg::PWR_ON);
    gpio = 1'b1;
    settle(10);
    cmpState(pmic_fsm_pkg::PWR_ON);
    gpio = 1'b0;
    waitState(pmic_fsm_pkg::SLEEP, 30);
    settle(50);
    cmpBits("drive", 20'hFD401, drive_ff);
    cmpBits("serialEnable", 20'h00001, {19'h00000, serEn});
    btnN = 1'b0;
    waitState(pmic_fsm_pkg::START_SEQ, 100);
    cmpBits("sleepBit", 20'h0, {19'h0, ctrlBits_ff.sleepReqBit});
    btnN = 1'b1;
    waitState(pmic_fsm_pkg::PWR_ON, 200);
    gpio = 1'b1;
    settle(4);
    gpio = 1'b0;
    writeCtrl(2, 1'b1);
    waitState(pmic_fsm_pkg::SLEEP, 30);
    writeCtrl(2, 1'b0);
    waitState(pmic_fsm_pkg::START_SEQ, 20);
    waitState(pmic_fsm_pkg::PWR_ON, 200);
    writeCtrl(0, 1'b1);
    waitState(pmic_fsm_pkg::PWR_OFF, 10);
    settle(2);
    cmpBits("drive", 20'h00000, drive_ff);
    // Button start: fault while held, then a clean start
    btnN = 1'b0;
    waitState(pmic_fsm_pkg::START_SEQ, 100);
    settle(50);
    cmpState(pmic_fsm_pkg::START_SEQ);
    fault = 1'b1;
    waitState(pmic_fsm_pkg::PWR_OFF, 10);
    fault = 1'b0;
    btnN = 1'b1;
    settle(20);
    btnN = 1'b0;
    waitState(pmic_fsm_pkg::START_SEQ, 100);
    settle(50);
    btnN = 1'b1;
    waitState(pmic_fsm_pkg::PWR_ON, 20);
    btnN = 1'b0;
    waitState(pmic_fsm_pkg::PWR_OFF, 100);
    btnN = 1'b1;
    settle(20);
    // Slow regulators: early release aborts the start
    lag = 8'hC8;
    btnN = 1'b0;
    waitState(pmic_fsm_pkg::START_SEQ, 100);
    btnN = 1'b1;
    waitState(pmic_fsm_pkg::PWR_OFF, 30);
    lag = 8'h03;
    writeCtrl(0, 1'b0);
    waitState(pmic_fsm_pkg::PWR_ON, 200);
    // Long hold: off, then a timed start sequence
    // Short hit turns it off and soft start follows; the hold goes on
    btnN = 1'b0;
    waitState(pmic_fsm_pkg::PWR_OFF, 100);
    waitState(pmic_fsm_pkg::PWR_ON, 100);
    waitState(pmic_fsm_pkg::PWR_OFF, 200);
    waitState(pmic_fsm_pkg::START_SEQ, 5);
    btnN = 1'b1;
    n = 0;
    while (state_ff === pmic_fsm_pkg::START_SEQ && n < 100) begin
      settle(1);
      n++;
    end
    cmpBits("cycleWait", 20'h1, {19'h0, n >= 28 && n <= 32});
    waitState(pmic_fsm_pkg::PWR_ON, 5);
    writeCtrl(1, 1'b1);
    waitState(pmic_fsm_pkg::PWR_OFF, 10);
    settle(1);
    cmpBits("alwaysOn", 20'h00000, {19'h00000, aoEn});
    writeCtrl(0, 1'b0);
    waitState(pmic_fsm_pkg::PWR_ON, 200);
    uv = 1'b1;
    settle(2);
    cmpState(pmic_fsm_pkg::PWR_OFF);
    cmpBits("ctrlBits", 20'h00008, {16'h0000, ctrlBits_ff});
    uv = 1'b0;
    // Second run with the OR strap
    strap = 4'hA;
    gpio = 1'b1;
    doReset();
    writeCtrl(0, 1'b0);
    waitState(pmic_fsm_pkg::PWR_ON, 200);
    gpio = 1'b0;
    waitState(pmic_fsm_pkg::SLEEP, 30);
    gpio = 1'b1;
    waitState(pmic_fsm_pkg::PWR_ON, 200);
    writeCtrl(3, 1'b1);
    waitState(pmic_fsm_pkg::DEEP_SLEEP, 30);
    settle(50);
    cmpBits("drive", 20'hFCC00, drive_ff);
    writeCtrl(3, 1'b0);
    waitState(pmic_fsm_pkg::PWR_ON, 200);
    complete_run();
  end
endmodule // tb_pmic_power_state_machine

bind pmic_power_state_machine pmic_fsm_checker i_chk (.mclk(mclk),
  .rst(rst), .input_undervoltage(input_undervoltage), .ctrl(ctrl),
  .powerOffWr(powerOffWr), .masterResetWr(masterResetWr),
  .state_ff(state_ff), .ctrlBits_ff(ctrlBits_ff), .drive_ff(drive_ff),
  .system_reset_out_n_ff(system_reset_out_n_ff),
  .alwaysOnEnable_ff(alwaysOnEnable_ff),
  .defaultsLoad_ff(defaultsLoad_ff), .serialReset_ff(serialReset_ff),
  .serialEnable_ff(serialEnable_ff));
